// ### ccu_bcd_step.sv
// Two-digit BCD counter step with range check and repair value.
module ccu_bcd_step (
  input  wire logic       en,
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] fix,
  output logic      [7:0] nxt,
  output logic            carry
);
  import ccu_pkg::*;

  logic       valid;
  logic [7:0] inc;

  assign valid = (val[3:0] <= DIG_MAX) && (val[7:4] <= DIG_MAX) && (val >= lo) && (val <= hi);
  assign inc   = (val[3:0] == DIG_MAX) ? {val[7:4] + 4'h1, 4'h0} : val + 8'h01;
  // An out-of-range value is repaired instead of counted, so it never carries.
  assign nxt   = !en ? val : !valid ? fix : (val == hi) ? lo : inc;
  assign carry = en && valid && (val == hi);

endmodule : ccu_bcd_step

// ### ccu_calendar_rtc.sv
// Calendar clock unit: prescaler, BCD calendar, alarm and AXI4-Lite registers.
module ccu_calendar_rtc (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clock_kernel_clk,
  input  wire logic [ccu_pkg::AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ccu_pkg::AW-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic                       one_second_tick,
  output logic                       clock_irq_req
);
  import ccu_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic              kern_q_reg;
  logic [8:0]        pre_reg;
  logic              pin_reg;
  logic              run_reg;
  logic              mode24_reg;
  logic              hold_reg;
  logic              adj_reg;
  logic              pend_reg;
  logic              busy_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic              tbusy_reg;
  ccu_time_t         time_reg;
  ccu_date_t         date_reg;
  ccu_time_t         alarm_reg;
  logic              flag_reg;
  logic              irq_en_reg;
  logic              irq_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [AW-1:0]     awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ****************************************************************
  // Prescaler and trim
  // ****************************************************************
  // The kernel input is a 256 Hz level; each rising edge is one 1/256 s step.
  logic       k_step;
  logic       tick1;
  logic [8:0] trim_ext;
  logic [8:0] reload;
  logic [8:0] pre_next;

  assign k_step   = clock_kernel_clk & ~kern_q_reg;
  assign tick1    = k_step && (pre_reg == PRE_END);
  assign trim_ext = {{2{trim_reg[TRIM_W-1]}}, trim_reg};
  // Reload marks the prescaler turning to 0xff; a pending trim bends that reload.
  assign reload   = tbusy_reg ? PRE_RELOAD + trim_ext : PRE_RELOAD;
  assign pre_next = tick1 ? reload : k_step ? pre_reg - PRE_STEP : pre_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kern_q_reg <= 1'b0;
      pre_reg    <= PRE_RELOAD;
      pin_reg    <= 1'b0;
    end else begin
      kern_q_reg <= clock_kernel_clk;
      pre_reg    <= pre_next;
      if (tick1) begin
        pin_reg <= 1'b1;
      end else if (k_step && (pre_reg == PRE_HALF)) begin
        pin_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register access decode
  // ****************************************************************
  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_time;
  logic        wr_date;
  logic        wr_alarm;
  logic        wr_irq;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] v_ctrl;
  logic [31:0] v_time;
  logic [31:0] v_date;
  logic [31:0] v_alarm;
  logic [31:0] v_irq;
  logic [31:0] rd_word;
  logic [31:0] cur_word;
  logic [31:0] wm;
  logic [31:0] mw;

  assign wr_fire  = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign wr_ctrl  = wr_fire && (awaddr_reg == OFS_CTRL);
  assign wr_time  = wr_fire && (awaddr_reg == OFS_TIME);
  assign wr_date  = wr_fire && (awaddr_reg == OFS_DATE);
  assign wr_alarm = wr_fire && (awaddr_reg == OFS_ALARM);
  assign wr_irq   = wr_fire && (awaddr_reg == OFS_IRQ);
  assign wr_hit   = wr_ctrl | wr_time | wr_date | wr_alarm | wr_irq;

  // Trim reads back as zero; only its busy flag is visible.
  assign v_ctrl  = {16'h0000, tbusy_reg, 7'h00, 1'b0, busy_reg, hold_reg, mode24_reg,
                    1'b0, adj_reg, 1'b0, run_reg};
  assign v_time  = {9'h000, time_reg.pm, time_reg.hour, 1'b0, time_reg.min, 1'b0, time_reg.sec};
  assign v_date  = {5'h00, date_reg.wday, date_reg.year, 3'h0, date_reg.month, 2'h0,
                    date_reg.day};
  assign v_alarm = {9'h000, alarm_reg.pm, alarm_reg.hour, 1'b0, alarm_reg.min, 1'b0,
                    alarm_reg.sec};
  assign v_irq   = {23'h000000, irq_en_reg, 7'h00, flag_reg};

  assign rd_hit  = (araddr == OFS_CTRL) || (araddr == OFS_TIME) || (araddr == OFS_DATE) ||
                   (araddr == OFS_ALARM) || (araddr == OFS_IRQ);
  assign rd_word = (araddr == OFS_CTRL)  ? v_ctrl  :
                   (araddr == OFS_TIME)  ? v_time  :
                   (araddr == OFS_DATE)  ? v_date  :
                   (araddr == OFS_ALARM) ? v_alarm :
                   (araddr == OFS_IRQ)   ? v_irq   : 32'h00000000;
  assign cur_word = wr_ctrl  ? v_ctrl  :
                    wr_time  ? v_time  :
                    wr_date  ? v_date  :
                    wr_alarm ? v_alarm : v_irq;
  assign wm = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign mw = (cur_word & ~wm) | (wdata_reg & wm);

  // ****************************************************************
  // Calendar step chain
  // ****************************************************************
  logic       adj_go;
  logic       cnt_go;
  logic       upd;
  logic       pend_set;
  logic [7:0] sec_s;
  logic [7:0] min_s;
  logic [7:0] hr_s;
  logic [7:0] day_s;
  logic [7:0] mon_s;
  logic [7:0] yr_s;
  logic       sec_c;
  logic       min_c;
  logic       hr_c;
  logic       day_c;
  logic       mon_c;
  logic       min_en;
  logic       pm_flip;
  logic       day_en;
  logic [7:0] hr_lo;
  logic [7:0] hr_hi;
  logic [1:0] leap_sum;
  logic       leap;
  logic [7:0] mon8;
  logic [7:0] dim;
  logic [2:0] wday_new;
  ccu_time_t  time_n;
  ccu_date_t  date_n;

  assign adj_go   = adj_reg;
  // Hold and adjust defer the tick into a single pending step; a stopped clock drops it.
  assign cnt_go   = run_reg && !hold_reg && !adj_go && (tick1 || pend_reg);
  assign pend_set = tick1 && run_reg && (hold_reg || adj_go || pend_reg);
  assign upd      = cnt_go | adj_go;

  ccu_bcd_step u_sec (.en(cnt_go), .val({1'b0, time_reg.sec}), .lo(BCD_ZERO),
    .hi(SEC_MAX), .fix(BCD_ZERO), .nxt(sec_s), .carry(sec_c));

  assign min_en = adj_go ? ({1'b0, time_reg.sec} >= HALF_MIN) : sec_c;

  ccu_bcd_step u_min (.en(min_en), .val({1'b0, time_reg.min}), .lo(BCD_ZERO),
    .hi(SEC_MAX), .fix(BCD_ZERO), .nxt(min_s), .carry(min_c));

  assign hr_lo = mode24_reg ? BCD_ZERO : BCD_ONE;
  assign hr_hi = mode24_reg ? HOUR24_MAX : HOUR12_MAX;

  ccu_bcd_step u_hr (.en(min_c), .val({2'h0, time_reg.hour}), .lo(hr_lo),
    .hi(hr_hi), .fix(hr_lo), .nxt(hr_s), .carry(hr_c));

  assign pm_flip = !mode24_reg && min_c && ({2'h0, time_reg.hour} == HOUR12_PRE);
  assign day_en  = mode24_reg ? hr_c : (pm_flip && time_reg.pm);

  // BCD year is divisible by four when ones plus twice the tens parity is.
  assign leap_sum = date_reg.year[1:0] + {date_reg.year[4], 1'b0};
  assign leap     = (date_reg.year != BCD_ZERO) && (leap_sum == 2'h0);
  assign mon8     = {3'h0, date_reg.month};
  assign dim      = (mon8 == MON_FEB) ? (leap ? DAYS_29 : DAYS_28) :
                    ((mon8 == MON_APR) || (mon8 == MON_JUN) || (mon8 == MON_SEP) ||
                     (mon8 == MON_NOV)) ? DAYS_30 : DAYS_31;

  ccu_bcd_step u_day (.en(day_en), .val({2'h0, date_reg.day}), .lo(BCD_ONE),
    .hi(dim), .fix(BCD_ONE), .nxt(day_s), .carry(day_c));

  ccu_bcd_step u_mon (.en(day_c), .val(mon8), .lo(BCD_ONE),
    .hi(MON_MAX), .fix(BCD_ONE), .nxt(mon_s), .carry(mon_c));

  ccu_bcd_step u_yr (.en(mon_c), .val(date_reg.year), .lo(BCD_ZERO),
    .hi(YEAR_MAX), .fix(BCD_ZERO), .nxt(yr_s), .carry());

  assign wday_new = !day_en ? date_reg.wday :
                    (date_reg.wday >= WDAY_MAX) ? 3'h0 : date_reg.wday + 3'h1;

  assign time_n = '{pm: time_reg.pm ^ pm_flip, hour: hr_s[5:0], min: min_s[6:0],
                    sec: adj_go ? 7'h00 : sec_s[6:0]};
  assign date_n = '{wday: wday_new, year: yr_s, month: mon_s[4:0], day: day_s[5:0]};

  // ****************************************************************
  // Control and calendar registers
  // ****************************************************************
  // A software write to a counter wins over a step in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_reg    <= 1'b0;
      mode24_reg <= 1'b0;
      hold_reg   <= 1'b0;
      adj_reg    <= 1'b0;
      pend_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      trim_reg   <= '0;
      tbusy_reg  <= 1'b0;
      time_reg   <= TIME_RST;
      date_reg   <= DATE_RST;
      alarm_reg  <= TIME_RST;
    end else begin
      adj_reg  <= wr_ctrl && mw[CB_ADJ];
      pend_reg <= pend_set | (pend_reg & ~cnt_go);
      busy_reg <= upd | (busy_reg & ~k_step);
      if (wr_ctrl) begin
        run_reg    <= mw[CB_RUN];
        mode24_reg <= mw[CB_MODE24];
        hold_reg   <= mw[CB_HOLD] & ~tbusy_reg;
      end
      if (wr_ctrl && wstrb_reg[TRIM_LANE] && !tbusy_reg) begin
        trim_reg  <= mw[CB_TRIM_LO +: TRIM_W];
        tbusy_reg <= 1'b1;
      end else if (tick1) begin
        tbusy_reg <= 1'b0;
      end
      if (wr_time) begin
        time_reg <= '{pm: mw[22], hour: mw[21:16], min: mw[14:8], sec: mw[6:0]};
      end else if (upd) begin
        time_reg <= time_n;
      end
      if (wr_date) begin
        date_reg <= '{wday: mw[26:24], year: mw[23:16], month: mw[12:8], day: mw[5:0]};
      end else if (upd) begin
        date_reg <= date_n;
      end
      if (wr_alarm) begin
        alarm_reg <= '{pm: mw[22], hour: mw[21:16], min: mw[14:8], sec: mw[6:0]};
      end
    end
  end

  // ****************************************************************
  // Alarm
  // ****************************************************************
  logic al_match;
  logic flag_set;
  logic flag_clr;

  assign al_match = (time_reg.sec == alarm_reg.sec) && (time_reg.min == alarm_reg.min) &&
                    (time_reg.hour == alarm_reg.hour) &&
                    (mode24_reg || (time_reg.pm == alarm_reg.pm));
  // The flag is raised as busy ends, 1/256 s after the matching step.
  assign flag_set = k_step && busy_reg && al_match;
  assign flag_clr = wr_irq && wstrb_reg[0] && wdata_reg[IB_FLAG];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_reg   <= 1'b0;
      irq_en_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      flag_reg <= flag_set | (flag_reg & ~flag_clr);
      irq_reg  <= flag_reg & irq_en_reg;
      if (wr_irq) begin
        irq_en_reg <= mw[IB_EN];
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;

  assign aw_hs = awvalid & awready_reg;
  assign w_hs  = wvalid & wready_reg;
  assign b_hs  = bvalid_reg & bready;
  assign ar_hs = arvalid & arready_reg;
  assign r_hs  = rvalid_reg & rready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        aw_got_reg  <= 1'b1;
        awaddr_reg  <= awaddr;
      end else if (wr_fire) begin
        aw_got_reg <= 1'b0;
      end else if (b_hs) begin
        awready_reg <= 1'b1;
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        w_got_reg  <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end else if (wr_fire) begin
        w_got_reg <= 1'b0;
      end else if (b_hs) begin
        wready_reg <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  assign awready         = awready_reg;
  assign wready          = wready_reg;
  assign bvalid          = bvalid_reg;
  assign bresp           = bresp_reg;
  assign arready         = arready_reg;
  assign rvalid          = rvalid_reg;
  assign rdata           = rdata_reg;
  assign rresp           = rresp_reg;
  assign one_second_tick = pin_reg;
  assign clock_irq_req   = irq_reg;

endmodule : ccu_calendar_rtc

// ### ccu_calendar_rtc_props.sv
// Bus handshake and tick assertions for the calendar clock unit.
module ccu_calendar_rtc_props
  import ccu_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        one_second_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_taken; arvalid && arready; endsequence
  property p_wr_answer; s_wr_taken |-> ##2 bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_block; s_wr_taken |=> !awready && !wready; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken twice");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_code; bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR; endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response");
  property p_rd_answer; s_rd_taken |=> rvalid && !arready; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // The pin must start low, so this one also watches the reset cycles.
  property p_tick_rst; disable iff (1'h0) sys_rst |=> !one_second_tick; endproperty
  a_tick_rst: assert property (p_tick_rst) else $error("tick high in reset");
  property p_tick_width; $rose(one_second_tick) |=> one_second_tick[*8]; endproperty
  a_tick_width: assert property (p_tick_width) else $error("tick too short");
endmodule : ccu_calendar_rtc_props

bind ccu_calendar_rtc ccu_calendar_rtc_props u_props (.clk, .sys_rst, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .one_second_tick);

// ### ccu_calendar_rtc_test.sv
// Self-checking bench for the calendar clock unit.
module ccu_calendar_rtc_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ccu_pkg::*;
  logic        clk = 1'h0, sys_rst = 1'h1, clock_kernel_clk = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got, seed = 32'hbd9c5c6a;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, gresp, kdiv = 2'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, one_second_tick, clock_irq_req;
  logic [31:0] cm [4] = '{32'h11, 32'h11, 32'h01, 32'h11};
  // A bad counter is repaired when its own count-up comes, so the last case carries into it.
  logic [31:0] ti [4] = '{32'h00235959, 32'h00235959, 32'h00115959, 32'h00235959};
  logic [31:0] di [4] = '{32'h06040228, 32'h03000228, 32'h00000105, 32'h07a01531};
  logic [31:0] te [4] = '{32'h0, 32'h0, 32'h00520000, 32'h0};
  logic [31:0] de [4] = '{32'h00040229, 32'h04000301, 32'h00000105, 32'h00a00101};
  int          err_total = 0, n_checks = 0, m, s, t;
  time         t0;

  ccu_calendar_rtc dut (.clk, .sys_rst, .clock_kernel_clk, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .one_second_tick, .clock_irq_req);

  always #2 clk = ~clk;
  // Kernel steps every 8 clocks: a second is 2048 cycles, which keeps the run short.
  always @(posedge clk) begin
    kdiv <= kdiv + 2'h1;
    if (&kdiv) clock_kernel_clk <= ~clock_kernel_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction : bcd
  function automatic logic [31:0] adj_exp(input int mi, input int se);
    return {16'h0, bcd(se >= 30 ? mi + 1 : mi), 8'h00};
  endfunction : adj_exp

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] ac);
    n_checks++;
    if (ac !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, ac);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    gresp  = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    got    = rdata;
    gresp  = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask : rd
  // Counter writes start only once busy has dropped after a tick.
  task automatic sync();
    @(posedge one_second_tick);
    repeat (16) @(posedge clk);
  endtask : sync
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(8'h14);
    chk("unmapped", {30'h0, RESP_SLVERR}, {got[29:0], gresp});
    wr(8'h14, 32'h0);
    chk("wr unmapped", {30'h0, RESP_SLVERR}, {30'h0, gresp});
    sync();
    rd(OFS_TIME);
    chk("stopped", 32'h00010000, got);
    rd(OFS_DATE);
    chk("date", 32'h00000101, got);
    for (int i = 0; i < 4; i++) begin
      sync();
      wr(OFS_CTRL, cm[i]);
      wr(OFS_TIME, ti[i]);
      wr(OFS_DATE, di[i]);
      @(posedge one_second_tick);
      rd(OFS_CTRL);
      chk("busy", cm[i] | 32'h40, got);
      rd(OFS_TIME);
      chk("time", te[i], got);
      rd(OFS_DATE);
      chk("date", de[i], got);
    end
    sync();
    wr(OFS_CTRL, 32'h31);
    wr(OFS_TIME, 32'h00100000);
    repeat (2) @(posedge one_second_tick);
    rd(OFS_TIME);
    chk("held", 32'h00100000, got);
    wr(OFS_CTRL, 32'h11);
    rd(OFS_TIME);
    chk("resumed", 32'h00100001, got);
    for (int i = 0; i < 4; i++) begin
      m = xs() % 59;
      s = i == 0 ? 29 : i == 1 ? 30 : xs() % 60;
      sync();
      wr(OFS_TIME, {16'h0, bcd(m), bcd(s)});
      wr(OFS_CTRL, 32'h15);
      repeat (2) @(posedge clk);
      rd(OFS_TIME);
      chk("adjust", adj_exp(m, s), got);
    end
    sync();
    wr(OFS_IRQ, 32'h0);
    wr(OFS_TIME, 32'h00100005);
    wr(OFS_ALARM, 32'h00100006);
    wr(OFS_IRQ, 32'h101);
    @(posedge one_second_tick);
    repeat (12) @(posedge clk);
    chk("irq", 32'h1, {31'h0, clock_irq_req});
    wr(OFS_IRQ, 32'h0);
    chk("masked", 32'h0, {31'h0, clock_irq_req});
    wr(OFS_IRQ, 32'h1);
    rd(OFS_IRQ);
    chk("cleared", 32'h0, got);
    for (int i = 0; i < 2; i++) begin
      t = i ? 63 : -64;
      sync();
      wr(OFS_CTRL, {16'h0, 1'h0, 7'(t), 8'h11});
      // A second value while busy must be dropped, so the period shows the first.
      wr(OFS_CTRL, {16'h0, 1'h0, 7'(t) ^ 7'h7f, 8'h11});
      rd(OFS_CTRL);
      chk("trim busy", 32'h8011, got);
      @(posedge one_second_tick);
      t0 = $time;
      repeat (12) @(posedge clk);
      rd(OFS_CTRL);
      chk("trim done", 32'h11, got);
      @(posedge one_second_tick);
      chk("trim", 32'((256 + t) * 32), 32'($time - t0));
    end
    wrap_up();
  end
endmodule : ccu_calendar_rtc_test

// ### ccu_pkg.sv
// Constants, register map and carrier types of the calendar clock unit.
package ccu_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int             AW        = 8;
  localparam logic [AW-1:0]  OFS_CTRL  = 8'h00;
  localparam logic [AW-1:0]  OFS_TIME  = 8'h04;
  localparam logic [AW-1:0]  OFS_DATE  = 8'h08;
  localparam logic [AW-1:0]  OFS_ALARM = 8'h0c;
  localparam logic [AW-1:0]  OFS_IRQ   = 8'h10;

  localparam int             CB_RUN     = 0;
  localparam int             CB_ADJ     = 2;
  localparam int             CB_MODE24  = 4;
  localparam int             CB_HOLD    = 5;
  localparam int             CB_BUSY    = 6;
  localparam int             CB_TRIM_LO = 8;
  localparam int             CB_TBUSY   = 15;
  localparam int             TRIM_W     = 7;
  localparam int             TRIM_LANE  = 1;
  localparam int             IB_FLAG    = 0;
  localparam int             IB_EN      = 8;

  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Prescale and calendar limits
  // ****************************************************************
  localparam logic [8:0]     PRE_RELOAD = 9'h0ff;
  localparam logic [8:0]     PRE_HALF   = 9'h080;
  localparam logic [8:0]     PRE_END    = 9'h000;
  localparam logic [8:0]     PRE_STEP   = 9'h001;

  localparam logic [3:0]     DIG_MAX    = 4'h9;
  localparam logic [7:0]     BCD_ZERO   = 8'h00;
  localparam logic [7:0]     BCD_ONE    = 8'h01;
  localparam logic [7:0]     SEC_MAX    = 8'h59;
  localparam logic [7:0]     HALF_MIN   = 8'h30;
  localparam logic [7:0]     HOUR24_MAX = 8'h23;
  localparam logic [7:0]     HOUR12_MAX = 8'h12;
  localparam logic [7:0]     HOUR12_PRE = 8'h11;
  localparam logic [7:0]     MON_MAX    = 8'h12;
  localparam logic [7:0]     YEAR_MAX   = 8'h99;
  localparam logic [7:0]     MON_FEB    = 8'h02;
  localparam logic [7:0]     MON_APR    = 8'h04;
  localparam logic [7:0]     MON_JUN    = 8'h06;
  localparam logic [7:0]     MON_SEP    = 8'h09;
  localparam logic [7:0]     MON_NOV    = 8'h11;
  localparam logic [7:0]     DAYS_28    = 8'h28;
  localparam logic [7:0]     DAYS_29    = 8'h29;
  localparam logic [7:0]     DAYS_30    = 8'h30;
  localparam logic [7:0]     DAYS_31    = 8'h31;
  localparam logic [2:0]     WDAY_MAX   = 3'h6;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic       pm;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } ccu_time_t;

  typedef struct packed {
    logic [2:0] wday;
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
  } ccu_date_t;

  localparam ccu_time_t      TIME_RST = '{pm: 1'b0, hour: 6'h01, min: 7'h00, sec: 7'h00};
  localparam ccu_date_t      DATE_RST = '{wday: 3'h0, year: 8'h00, month: 5'h01, day: 6'h01};

endpackage : ccu_pkg
